// ---- hdl/nv_pkg.sv ----
// shared constants for the data nonvolatile array access controller
package nv_pkg;
   // array geometry
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int DEPTH   = 256;

   // register port
   localparam int REG_ADDR_W = 3;
   localparam logic [REG_ADDR_W-1:0] REG_DATA   = 3'h0;
   localparam logic [REG_ADDR_W-1:0] REG_ADDR   = 3'h1;
   localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 3'h2;
   localparam logic [REG_ADDR_W-1:0] REG_UNLOCK = 3'h3;
   localparam logic [REG_ADDR_W-1:0] REG_PFLAG  = 3'h4;

   // control register fields
   localparam int CTRL_RD   = 0;
   localparam int CTRL_WR   = 1;
   localparam int CTRL_PROGRAM_ENABLE = 2;
   localparam int CTRL_ERR  = 3;
   // peripheral flag register field
   localparam int PFLAG_DONE = 7;

   // reset values and fixed data
   localparam logic [DATA_W-1:0] DATA_RESET  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   localparam logic [DATA_W-1:0] READ_ZERO   = 8'h00;
   localparam logic [3:0]        CTRL_UPPER  = 4'h0;
   localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 8'hAA;

   // timing
   localparam int CLOCK_HZ         = 25_000_000;
   localparam int POWERUP_MS       = 64;
   localparam int POWERUP_CYCLES   = POWERUP_MS * (CLOCK_HZ / 1000);
   localparam int WRITE_CYCLES_DEF = 100_000;
   localparam int UNLOCK_GAP_DEF   = 2;

   // write sequencer states
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_KEY1  = 4'b0010,
      S_ARMED = 4'b0100,
      S_BUSY  = 4'b1000
   } seq_t;
endpackage

// ---- hdl/nv_mem_if.sv ----
// connection between the access controller and its storage array
`timescale 1ns/1ps
interface nv_mem_if;
   logic                     we;
   logic [nv_pkg::ADDR_W-1:0] waddr;
   logic [nv_pkg::DATA_W-1:0] wdata;
   logic [nv_pkg::ADDR_W-1:0] raddr;
   logic [nv_pkg::DATA_W-1:0] rdata;
   logic [nv_pkg::ADDR_W-1:0] paddr;
   logic [nv_pkg::DATA_W-1:0] pdata;

   modport ctrl (output we, waddr, wdata, raddr, paddr, input rdata, pdata);
   modport array (input we, waddr, wdata, raddr, paddr, output rdata, pdata);
endinterface

// ---- hdl/nv_array.sv ----
// byte storage array with one write port and two registered read ports
`timescale 1ns/1ps
module nv_array (
   // clock
   input wire logic clock,
   // array access
   nv_mem_if.array  bus
);
   import nv_pkg::*;

   logic [DATA_W-1:0] cells [DEPTH];

   // no reset on the cells: contents are meant to survive every reset
   always_ff @(posedge clock) begin
      if (bus.we) begin
         cells[bus.waddr] <= bus.wdata;
      end
      bus.rdata <= cells[bus.raddr];
      bus.pdata <= cells[bus.paddr];
   end
endmodule

// ---- hdl/data_eeprom_access_controller.sv ----
// register front end, unlock sequencer and self-timed writer for the data array
`timescale 1ns/1ps
// Operation
// RULE1 - 256 byte array, 8-bit address
// RULE2 - each write erases then programs the byte
// RULE3 - internal timer sets write length
// RULE4 - protected: programmer reads zeros, cpu unaffected
// RULE5 - data and address registers hold access
// RULE6 - control upper four bits read zero
// RULE7 - strobes set by software, cleared by hardware
// RULE8 - write enable gates writes, clear at power-up
// RULE9 - error flag on aborted write
// RULE10 - abort clears data and address registers
// RULE11 - done flag set, software clears it
// RULE12 - unlock register stores nothing, reads zero
// RULE13 - software leaves registers alone while busy
// RULE14 - read byte lands next cycle
// RULE15 - data register holds byte until replaced
// RULE16 - 55h, AAh, then strobe with exact timing
// RULE17 - write strobe blocked unless enable set
// RULE18 - clearing enable does not stop write
// RULE19 - no writes during power-up timer
// RULE20 - write length is a cycle parameter
// RULE21 - read strobe ignored during write
module data_eeprom_access_controller #(
   parameter int WRITE_CYCLES   = nv_pkg::WRITE_CYCLES_DEF,
   parameter int POWERUP_CYCLES = nv_pkg::POWERUP_CYCLES,
   parameter int UNLOCK_GAP     = nv_pkg::UNLOCK_GAP_DEF
) (
   // clock and power-on reset
   input  wire logic                          clock,
   input  wire logic                          reset,
   // register port
   input  wire logic [nv_pkg::REG_ADDR_W-1:0] regAddr,
   input  wire logic [nv_pkg::DATA_W-1:0]     regWriteData,
   input  wire logic                          regWrite,
   input  wire logic                          regRead,
   output logic      [nv_pkg::DATA_W-1:0]     regReadData,
   // system resets that may cut a write short, and the sleep state that masks the watchdog
   input  wire logic                          externalReset,
   input  wire logic                          watchdogReset,
   input  wire logic                          sleeping,
   input  wire logic                          brownoutReset,
   // external programmer port
   input  wire logic                          codeProtect,
   input  wire logic [nv_pkg::ADDR_W-1:0]     progAddr,
   output logic      [nv_pkg::DATA_W-1:0]     progReadData,
   // status
   output logic                               programDoneFlag
);
   import nv_pkg::*;

   localparam int TW = $clog2(WRITE_CYCLES + 1);
   localparam int PW = $clog2(POWERUP_CYCLES + 1);
   localparam logic [TW-1:0] WRITE_LAST   = TW'(WRITE_CYCLES - 1);
   localparam logic [PW-1:0] POWERUP_LOAD = PW'(POWERUP_CYCLES - 1);
   localparam logic [3:0]    GAP_LAST     = 4'(UNLOCK_GAP - 1);

   typedef struct packed {
      seq_t              seq;
      logic [3:0]        gap;
      logic [DATA_W-1:0] data;
      logic [ADDR_W-1:0] addr;
      logic              rd;
      logic              program_enable;
      logic              err;
      logic              done;
      logic [TW-1:0]     timer;
      logic [ADDR_W-1:0] latchAddr;
      logic [DATA_W-1:0] latchData;
      logic [PW-1:0]     pwrt;
      logic [DATA_W-1:0] readData;
      logic              progMask;
      logic [DATA_W-1:0] progReadData;
   } state_t;

   state_t st;
   state_t next_st;

   logic abortAny;
   logic wrBit;
   logic gapHit;
   logic eraseStep;
   logic programStep;

   nv_mem_if memBus ();

   nv_array u_array (
      .clock (clock),
      .bus   (memBus.array)
   );

   // a watchdog expiry while sleeping is a wake-up, not a reset
   assign abortAny    = externalReset | (watchdogReset & ~sleeping) | brownoutReset; // RULE9
   assign wrBit       = (st.seq == S_BUSY);
   assign gapHit      = (st.gap == GAP_LAST);
   assign eraseStep   = wrBit && (st.timer == '0);
   assign programStep = wrBit && (st.timer == WRITE_LAST) && !abortAny;

   // erase lands first, program value only at the very end of the timed cycle
   assign memBus.we    = eraseStep | programStep; // RULE2
   assign memBus.waddr = st.latchAddr; // RULE1
   assign memBus.wdata = programStep ? st.latchData : ERASED_BYTE; // RULE2
   assign memBus.raddr = st.addr; // RULE5
   assign memBus.paddr = progAddr;

   always_comb begin
      next_st = st;

      // read finishes one cycle after the strobe, then the strobe drops
      if (st.rd) begin
         next_st.data = memBus.rdata; // RULE14
         next_st.rd   = 1'b0; // RULE7
      end

      if (st.pwrt != '0) begin
         next_st.pwrt = st.pwrt - 1'b1; // RULE19
      end

      // software writes; the read strobe can only be set from here, the write strobe from S_ARMED below
      if (regWrite) begin
         if (regAddr == REG_DATA) begin
            next_st.data = regWriteData; // RULE15
         end else if (regAddr == REG_ADDR) begin
            next_st.addr = regWriteData; // RULE5
         end else if (regAddr == REG_CTRL) begin
            next_st.program_enable = regWriteData[CTRL_PROGRAM_ENABLE]; // RULE8
            next_st.err  = regWriteData[CTRL_ERR];
            if (regWriteData[CTRL_RD] && !wrBit) begin
               next_st.rd = 1'b1; // RULE21
            end
         end else if (regAddr == REG_PFLAG) begin
            next_st.done = regWriteData[PFLAG_DONE]; // RULE11
         end
      end

      next_st.gap = st.gap + 4'h1;
      case (st.seq)
         S_IDLE: begin
            if (regWrite && regAddr == REG_UNLOCK && regWriteData == UNLOCK_KEY1) begin
               next_st.seq = S_KEY1; // RULE16
               next_st.gap = 4'h0;
            end
         end
         S_KEY1: begin
            if (regWrite) begin
               if (regAddr == REG_UNLOCK && regWriteData == UNLOCK_KEY2 && gapHit) begin
                  next_st.seq = S_ARMED; // RULE16
                  next_st.gap = 4'h0;
               end else begin
                  next_st.seq = S_IDLE;
               end
            end else if (gapHit) begin
               next_st.seq = S_IDLE; // RULE16
            end
         end
         S_ARMED: begin
            if (regWrite) begin
               // enable must already be set; the same write cannot grant it
               if (regAddr == REG_CTRL && regWriteData[CTRL_WR] && gapHit
                   && st.program_enable && st.pwrt == '0) begin // RULE17
                  next_st.seq       = S_BUSY; // RULE19
                  next_st.timer     = '0;
                  next_st.latchAddr = st.addr;
                  next_st.latchData = st.data;
               end else begin
                  next_st.seq = S_IDLE;
               end
            end else if (gapHit) begin
               next_st.seq = S_IDLE; // RULE16
            end
         end
         S_BUSY: begin
            // runs from latched copies so late register edits cannot corrupt it
            if (st.timer == WRITE_LAST) begin
               next_st.seq  = S_IDLE; // RULE7
               // an abort on the final count programs nothing, so it must not report done
               next_st.done = next_st.done | !abortAny; // RULE11
               next_st.err  = 1'b0; // RULE9
            end else begin
               next_st.timer = st.timer + 1'b1; // RULE3 RULE20 RULE18
            end
         end
         default: begin
            next_st.seq = S_IDLE;
         end
      endcase

      // a system reset kills any write and wipes the access registers
      if (abortAny) begin
         if (wrBit) begin
            next_st.err = 1'b1; // RULE9
         end
         next_st.seq  = S_IDLE;
         next_st.rd   = 1'b0;
         next_st.program_enable = 1'b0;
         next_st.data = DATA_RESET; // RULE10
         next_st.addr = ADDR_RESET; // RULE10
      end

      next_st.readData = READ_ZERO;
      if (regRead) begin
         if (regAddr == REG_DATA) begin
            next_st.readData = st.rd ? memBus.rdata : st.data; // RULE14
         end else if (regAddr == REG_ADDR) begin
            next_st.readData = st.addr;
         end else if (regAddr == REG_CTRL) begin
            next_st.readData = {CTRL_UPPER, st.err, st.program_enable, wrBit, st.rd}; // RULE6
         end else if (regAddr == REG_UNLOCK) begin
            next_st.readData = READ_ZERO; // RULE12
         end else if (regAddr == REG_PFLAG) begin
            next_st.readData = READ_ZERO;
            next_st.readData[PFLAG_DONE] = st.done;
         end
      end

      // protection is sampled with the address so both stages line up
      next_st.progMask     = codeProtect;
      next_st.progReadData = st.progMask ? READ_ZERO : memBus.pdata; // RULE4
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st      <= '0;
         st.seq  <= S_IDLE;
         st.pwrt <= POWERUP_LOAD; // RULE19
      end else begin
         st <= next_st;
      end
   end

   assign regReadData     = st.readData;
   assign progReadData    = st.progReadData;
   assign programDoneFlag = st.done;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   AST_RD_NEXT_CYCLE: // RULE14
      assert property (regWrite && regAddr == REG_CTRL && regWriteData[CTRL_RD] && !wrBit
                       && !abortAny |=> st.rd ##1 (!st.rd && st.data == $past(memBus.rdata)))
      else $error("read strobe did not complete in one cycle");

   AST_RD_BLOCKED_BUSY: // RULE21
      assert property (wrBit && !st.rd |=> !st.rd)
      else $error("read strobe accepted during a write");

   AST_WR_NEEDS_ENABLE: // RULE17
      assert property ($rose(wrBit) |-> $past(st.program_enable) && $past(st.seq) == S_ARMED)
      else $error("write started without enable or unlock");

   AST_WR_COMPLETES: // RULE3
      assert property (wrBit && st.timer == WRITE_LAST && !abortAny
                       |=> !wrBit && st.done && !st.err)
      else $error("write did not complete on its final count");

   AST_WR_PERSISTS: // RULE18
      assert property (wrBit && st.timer != WRITE_LAST && !abortAny |=> wrBit)
      else $error("write ended early without a reset");

   AST_ABORT_FLAGS: // RULE9
      assert property (abortAny && wrBit
                       |=> st.err && !wrBit && st.data == DATA_RESET && st.addr == ADDR_RESET)
      else $error("aborted write not flagged or registers not cleared");

   AST_CTRL_UPPER_ZERO: // RULE6
      assert property (regRead && regAddr == REG_CTRL |=> regReadData[7:4] == CTRL_UPPER)
      else $error("control upper bits not zero");

   AST_UNLOCK_READS_ZERO: // RULE12
      assert property (regRead && regAddr == REG_UNLOCK |=> regReadData == READ_ZERO)
      else $error("unlock register read nonzero");

   AST_POWERUP_NO_WRITE: // RULE19
      assert property (st.pwrt != '0 |-> !wrBit)
      else $error("write active during power-up time");

   AST_PROTECT_ZERO: // RULE4
      assert property (codeProtect |-> ##2 progReadData == READ_ZERO)
      else $error("programmer saw data while protected");

   AST_DONE_SET_WINS: // RULE11
      assert property (programStep && regWrite && regAddr == REG_PFLAG |=> programDoneFlag)
      else $error("completion lost against software clear");

   AST_WR_EXACT_GAP: // RULE16
      assert property ($rose(wrBit) |-> $past(gapHit) && st.latchAddr == $past(st.addr)
                       && st.latchData == $past(st.data))
      else $error("write started off the unlock spacing or with wrong operands");

   AST_DATA_HOLDS: // RULE15
      assert property (!st.rd && !(regWrite && regAddr == REG_DATA) && !abortAny
                       |=> $stable(st.data))
      else $error("data register changed without a read or software write");

   AST_ADDR_HOLDS: // RULE5
      assert property (!(regWrite && regAddr == REG_ADDR) && !abortAny |=> $stable(st.addr))
      else $error("address register changed on its own");

   AST_ENABLE_KEPT: // RULE17
      assert property (!(regWrite && regAddr == REG_CTRL) && !abortAny |=> $stable(st.program_enable))
      else $error("write enable changed without software or reset");

   AST_DONE_HOLDS: // RULE11
      assert property (!programStep && !(regWrite && regAddr == REG_PFLAG)
                       |=> $stable(programDoneFlag))
      else $error("completion flag changed with no cause");
endmodule

// ---- testbench/data_eeprom_access_controller_tb.sv ----
// self-checking bench for the data array access controller
`timescale 1ns/1ps
module data_eeprom_access_controller_tb;
   import nv_pkg::*;

   localparam int WCYC = 10;
   localparam int PCYC = 16;
   localparam int GAP  = 2;

   logic                  clock;
   logic                  reset;
   logic [REG_ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0]     regWriteData;
   logic                  regWrite;
   logic                  regRead;
   logic [DATA_W-1:0]     regReadData;
   logic [2:0]            abortSrc;
   logic                  sleeping;
   logic                  codeProtect;
   logic [ADDR_W-1:0]     progAddr;
   logic [DATA_W-1:0]     progReadData;
   logic                  programDoneFlag;
   int                    bad_count;
   int                    num_checks;
   int                    cycles;

   data_eeprom_access_controller #(
      .WRITE_CYCLES  (WCYC),
      .POWERUP_CYCLES(PCYC),
      .UNLOCK_GAP    (GAP)
   ) u_dut (
      .clock          (clock),
      .reset          (reset),
      .regAddr        (regAddr),
      .regWriteData   (regWriteData),
      .regWrite       (regWrite),
      .regRead        (regRead),
      .regReadData    (regReadData),
      .externalReset  (abortSrc[0]),
      .watchdogReset  (abortSrc[1]),
      .sleeping       (sleeping),
      .brownoutReset  (abortSrc[2]),
      .codeProtect    (codeProtect),
      .progAddr       (progAddr),
      .progReadData   (progReadData),
      .programDoneFlag(programDoneFlag)
   );

   always #20 clock = ~clock;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite     <= 1'b1;
      regAddr      <= a;
      regWriteData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [REG_ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      d = regReadData;
   endtask

   // the write task spacing of two cycles matches the unlock gap of 2
   task automatic start_write(input logic [7:0] a, input logic [7:0] d, input int extra);
      wr(REG_ADDR, a);
      wr(REG_DATA, d);
      wr(REG_CTRL, 8'h04);
      wr(REG_UNLOCK, UNLOCK_KEY1);
      repeat (extra) @(posedge clock);
      wr(REG_UNLOCK, UNLOCK_KEY2);
      wr(REG_CTRL, 8'h06);
   endtask

   task automatic wait_idle();
      logic [7:0] v;
      int         n;
      n = 0;
      v = 8'h02;
      while (v[CTRL_WR] !== 1'b0 && n < WCYC) begin
         rd(REG_CTRL, v);
         n++;
      end
      check(v & 8'h02, 8'h00);
   endtask

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end

   initial begin
      logic [7:0] v;
      clock = 1'b0; reset = 1'b1; regAddr = '0; regWriteData = '0; regWrite = 1'b0;
      regRead = 1'b0; abortSrc = '0; sleeping = 1'b0; codeProtect = 1'b0; progAddr = '0;
      bad_count = 0; num_checks = 0; cycles = 0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      rd(REG_DATA, v);   check(v, DATA_RESET);
      rd(REG_ADDR, v);   check(v, ADDR_RESET);
      rd(REG_CTRL, v);   check(v, 8'h00);
      rd(REG_UNLOCK, v); check(v, READ_ZERO);
      rd(REG_PFLAG, v);  check(v, 8'h00);
      rd(3'h5, v);       check(v, 8'h00);
      // second reset, then a sequence inside the power-up window
      @(posedge clock) reset <= 1'b1;
      @(posedge clock) reset <= 1'b0;
      start_write(8'h40, 8'h5A, 0);
      rd(REG_CTRL, v);   check(v, 8'h04);
      rd(REG_PFLAG, v);  check(v, 8'h00);
      rd(REG_DATA, v);   check(v, 8'h5A);
      rd(REG_ADDR, v);   check(v, 8'h40);
      wr(REG_CTRL, 8'hF8);
      rd(REG_CTRL, v);   check(v, 8'h08);
      wr(REG_CTRL, 8'h00);
      // strobe without enable
      wr(REG_UNLOCK, UNLOCK_KEY1);
      wr(REG_UNLOCK, UNLOCK_KEY2);
      wr(REG_CTRL, 8'h02);
      rd(REG_CTRL, v);   check(v, 8'h00);
      // unlock spacing off by one cycle
      start_write(8'h40, 8'h5A, 1);
      rd(REG_CTRL, v);   check(v, 8'h04);
      // full write to the top address
      start_write(8'hFF, 8'h3C, 0);
      rd(REG_CTRL, v);   check(v, 8'h06);
      wr(REG_CTRL, 8'h01);
      rd(REG_CTRL, v);   check(v, 8'h02);
      rd(REG_DATA, v);   check(v, 8'h3C);
      wait_idle();
      rd(REG_CTRL, v);   check(v, 8'h00);
      rd(REG_PFLAG, v);  check(v, 8'h80);
      check({7'h00, programDoneFlag}, 8'h01);
      wr(REG_PFLAG, 8'h00);
      rd(REG_PFLAG, v);  check(v, 8'h00);
      wr(REG_DATA, 8'h00);
      wr(REG_CTRL, 8'h01);
      rd(REG_DATA, v);   check(v, 8'h3C);
      rd(REG_CTRL, v);   check(v, 8'h00);
      rd(REG_DATA, v);   check(v, 8'h3C);
      // programmer port, open then protected
      progAddr <= 8'hFF;
      repeat (3) @(posedge clock);
      #1 check(progReadData, 8'h3C);
      codeProtect <= 1'b1;
      repeat (3) @(posedge clock);
      #1 check(progReadData, READ_ZERO);
      // each abort source cuts a write at address 00h; the last one arrives asleep
      for (int k = 0; k < 4; k++) begin
         start_write(8'h00, 8'h12 + k[7:0], 0);
         sleeping <= (k == 3);
         repeat (3) @(posedge clock);
         abortSrc <= (k == 3) ? 3'b010 : 3'b001 << k;
         @(posedge clock) abortSrc <= '0;
         if (k < 3) begin
            rd(REG_CTRL, v);  check(v, 8'h08);
            rd(REG_DATA, v);  check(v, 8'h00);
            rd(REG_ADDR, v);  check(v, 8'h00);
            wr(REG_CTRL, 8'h01);
            rd(REG_DATA, v);  check(v, ERASED_BYTE);
         end else begin
            // software clear lands on the final busy cycle; completion must win
            repeat (WCYC - 6) @(posedge clock);
            wr(REG_PFLAG, 8'h00);
            wait_idle();
            rd(REG_PFLAG, v); check(v, 8'h80);
            rd(REG_CTRL, v);  check(v, 8'h04);
            wr(REG_CTRL, 8'h05);
            rd(REG_DATA, v);  check(v, 8'h15);
         end
      end
      sleeping <= 1'b0;
      wrap_up();
   end
endmodule
